//--- inc/jsr_defines.svh
/*
   Constants of the shutdown/readback test-port host: instructions, packets,
   step indices and TCK-cycle counts. Assumes a 10-bit instruction register.
*/
`ifndef JSR_DEFINES_SVH
`define JSR_DEFINES_SVH

// instructions, shifted lsb first
`define JSR_IR_SHUTDOWN   10'h3CD
`define JSR_IR_CFGIN      10'h3C5
`define JSR_IR_CFGOUT     10'h3C4

// configuration packets, shifted msb first
`define JSR_PKT_A         32'hFFFFFFFF
`define JSR_PKT_B         32'hAA995566
`define JSR_PKT_C         32'h20000000
`define JSR_PKT_D         32'h30008001
`define JSR_PKT_E         32'h00000004
`define JSR_PKT_F         32'h30002001
`define JSR_PKT_G         32'h00000000
`define JSR_PKT_H         32'h28006000
`define JSR_PKT_I         32'h48024090
`define JSR_PKT_NOOP      32'h20000000

// tck-cycle counts of the steps
`define JSR_N_ONE         32'h00000001
`define JSR_N_ENTER       32'h00000002
`define JSR_N_EXIT        32'h00000003
`define JSR_N_RESET       32'h00000005
`define JSR_N_IRLO        32'h00000009
`define JSR_N_RTI         32'h0000000C
`define JSR_N_PKT         32'h0000015F

// step indices
`define JSR_S_SHUT        5'h04
`define JSR_S_RTI         5'h07
`define JSR_S_CFGIN       5'h0A
`define JSR_S_CFGIN_MSB   5'h0B
`define JSR_S_PKT         5'h0E
`define JSR_S_PKT_LAST    5'h0F
`define JSR_S_TOIR        5'h10
`define JSR_S_IRENTER     5'h11
`define JSR_S_CFGOUT      5'h12
`define JSR_S_CFGOUT_MSB  5'h13
`define JSR_S_RB          5'h16
`define JSR_S_RB_LAST     5'h17
`define JSR_S_FINAL       5'h1A

`endif

//--- inc/jsr_pkg.sv
/*
   Types of the shutdown/readback test-port host.
   Assumes jsr_defines.svh supplies all numeric constants.
*/
package jsr_pkg;

   typedef enum logic [1:0] {JSR_IDLE, JSR_RUN} jsr_state_e;

   typedef enum logic [2:0] {
      JSR_TDI_ZERO, JSR_TDI_ONE, JSR_TDI_SHUT, JSR_TDI_CFGIN, JSR_TDI_CFGOUT, JSR_TDI_PKT
   } jsr_tdi_e;

   typedef struct packed {
      logic        tms;
      jsr_tdi_e    kind;
      logic [31:0] count;
      logic        sample;
   } jsr_step_s;

endpackage

//--- inc/jsr_stream_if.sv
/*
   Valid/ready word stream between the host sequencer and its buffer.
   Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface jsr_stream_if #(parameter int unsigned WIDTH = 32);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/jsr_host.sv
/*
   Test-port host that shuts a programmable device down and reads back its
   frame data, driving tck/tms/tdi and sampling tdo. Assumes the device's
   tap is idle or resettable at start and updates tdo on falling tck.
*/
// Contract
// R1 - shift shutdown low nine bits, tms low
// R2 - dwell twelve tck cycles in run-test/idle
// R3 - shift config-write low nine bits, tms low
// R4 - config-write msb one while tms high
// R5 - shift 352-bit packet series msb first
// R6 - last packet bit zero as tms rises
// R7 - three tms-high cycles reach select-ir
// R8 - two tms-low cycles enter shift-ir
// R9 - shift config-read low nine bits, tms low
// R10 - config-read msb one while tms high
// R11 - readback bits on tdo, count minus one
// R12 - last readback bit as tms rises
// R13 - finish with three tms-high cycles
// R14 - device prepends one pad frame, no packets
// R15 - device computes no crc on readback
// R16 - device decodes packets only after sync
`timescale 1ns/1ns
`default_nettype none
`include "jsr_defines.svh"
module jsr_host
   import jsr_pkg::*;
#(
   parameter int unsigned TCK_HALF = 4,
   parameter int unsigned RB_WORDS = 64,
   parameter int unsigned BUF_DEPTH = 2
)
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        start,
   input  wire logic        tdoPin,
   output var  logic        tck,
   output var  logic        tms,
   output var  logic        tdi,
   output var  logic        busy,
   output var  logic        done,
   output var  logic [31:0] rbData,
   output var  logic        rbValid,
   input  wire logic        rbReady
);
   // tdo passes four flops, so it needs at least three half-period cycles
   if (TCK_HALF < 3 || TCK_HALF > 127)
      $error("jsr_host: TCK_HALF must lie in 3..127");
   if (RB_WORDS < 1 || RB_WORDS > 1000000)
      $error("jsr_host: RB_WORDS must lie in 1..1000000");

   localparam logic [7:0]  PH_RISE = 8'(TCK_HALF - 1);
   localparam logic [7:0]  PH_LAST = 8'(2 * TCK_HALF - 1);
   localparam logic [31:0] RB_BITS = 32'(RB_WORDS * 32);
   localparam logic [9:0]  IR_SHUT = `JSR_IR_SHUTDOWN;
   localparam logic [9:0]  IR_CIN  = `JSR_IR_CFGIN;
   localparam logic [9:0]  IR_COUT = `JSR_IR_CFGOUT;

   function automatic jsr_step_s mk(input logic t, input jsr_tdi_e k,
                                    input logic [31:0] n, input logic s);
      jsr_step_s r;
      r.tms    = t;
      r.kind   = k;
      r.count  = n;
      r.sample = s;
      return r;
   endfunction

   function automatic logic [31:0] pktWord(input logic [3:0] i);
      case (i)
         4'h0:    pktWord = `JSR_PKT_A;
         4'h1:    pktWord = `JSR_PKT_B;
         4'h2:    pktWord = `JSR_PKT_C;
         4'h3:    pktWord = `JSR_PKT_D;
         4'h4:    pktWord = `JSR_PKT_E;
         4'h5:    pktWord = `JSR_PKT_F;
         4'h6:    pktWord = `JSR_PKT_G;
         4'h7:    pktWord = `JSR_PKT_H;
         4'h8:    pktWord = `JSR_PKT_I;
         default: pktWord = `JSR_PKT_NOOP;
      endcase
   endfunction

   // bit index counts from zero within the step
   function automatic logic tdiBit(input jsr_tdi_e k, input logic [31:0] idx);
      logic [31:0] w;
      w = pktWord(idx[8:5]);
      case (k)
         JSR_TDI_ONE:    tdiBit = 1'b1;
         JSR_TDI_SHUT:   tdiBit = IR_SHUT[idx[3:0]];
         JSR_TDI_CFGIN:  tdiBit = IR_CIN[idx[3:0]];
         JSR_TDI_CFGOUT: tdiBit = IR_COUT[idx[3:0]];
         JSR_TDI_PKT:    tdiBit = w[~idx[4:0]];
         default:        tdiBit = 1'b0;
      endcase
   endfunction

   function automatic jsr_step_s stepInfo(input logic [4:0] s);
      case (s)
         5'h00:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_RESET, 1'b0);
         5'h01:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ONE, 1'b0);
         5'h02:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         5'h03:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R1 shutdown instruction
         `JSR_S_SHUT:      stepInfo = mk(1'b0, JSR_TDI_SHUT, `JSR_N_IRLO, 1'b0);
         5'h05:            stepInfo = mk(1'b1, JSR_TDI_ONE, `JSR_N_ONE, 1'b0);
         5'h06:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ONE, 1'b0);
         // R2 idle dwell
         `JSR_S_RTI:       stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_RTI, 1'b0);
         5'h08:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         5'h09:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R3 R4 config-write instruction
         `JSR_S_CFGIN:     stepInfo = mk(1'b0, JSR_TDI_CFGIN, `JSR_N_IRLO, 1'b0);
         `JSR_S_CFGIN_MSB: stepInfo = mk(1'b1, JSR_TDI_ONE, `JSR_N_ONE, 1'b0);
         5'h0C:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         5'h0D:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R5 R6 packet series, last bit on the exit cycle
         `JSR_S_PKT:       stepInfo = mk(1'b0, JSR_TDI_PKT, `JSR_N_PKT, 1'b0);
         `JSR_S_PKT_LAST:  stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ONE, 1'b0);
         // R7 R8 back to shift-ir
         `JSR_S_TOIR:      stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_EXIT, 1'b0);
         `JSR_S_IRENTER:   stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R9 R10 config-read instruction
         `JSR_S_CFGOUT:    stepInfo = mk(1'b0, JSR_TDI_CFGOUT, `JSR_N_IRLO, 1'b0);
         `JSR_S_CFGOUT_MSB:stepInfo = mk(1'b1, JSR_TDI_ONE, `JSR_N_ONE, 1'b0);
         5'h14:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         5'h15:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R11 R12 readback, last bit on the exit cycle
         `JSR_S_RB:        stepInfo = mk(1'b0, JSR_TDI_ZERO, RB_BITS - 32'h1, 1'b1);
         `JSR_S_RB_LAST:   stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_ONE, 1'b1);
         5'h18:            stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_EXIT, 1'b0);
         5'h19:            stepInfo = mk(1'b0, JSR_TDI_ZERO, `JSR_N_ENTER, 1'b0);
         // R13 closing tms-high cycles
         default:          stepInfo = mk(1'b1, JSR_TDI_ZERO, `JSR_N_EXIT, 1'b0);
      endcase
   endfunction

   jsr_state_e  state_q;
   logic [7:0]  ph_q;
   logic [4:0]  step_q;
   logic [31:0] cnt_q;
   logic [31:0] rbShift_q;
   logic [4:0]  rbCnt_q;
   logic        wordValid_q;
   logic [31:0] wordData_q;
   logic        tdoSync;
   jsr_step_s   cur;
   jsr_step_s   nxt;
   logic        stall;
   logic        adv;
   logic        lastBit;

   jsr_stream_if #(.WIDTH(32)) fillBus ();

   jsr_pin_sync u_tdo_sync
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pinIn   (tdoPin),
      .pinOut  (tdoSync)
   );

   jsr_word_fifo #(.WIDTH(32), .DEPTH(BUF_DEPTH)) u_buf
   (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .fill     (fillBus),
      .outData  (rbData),
      .outValid (rbValid),
      .outReady (rbReady)
   );

   assign fillBus.valid = wordValid_q;
   assign fillBus.data  = wordData_q;

   always_comb
   begin
      cur     = stepInfo(step_q);
      nxt     = stepInfo(step_q + 5'h01);
      // an untaken word freezes tck high, so no readback bit is lost
      stall   = wordValid_q;
      adv     = state_q == JSR_RUN && ph_q == PH_LAST && !stall;
      lastBit = cnt_q == cur.count - 32'h1;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_q <= JSR_IDLE;
         ph_q    <= '0;
         step_q  <= '0;
         cnt_q   <= '0;
         tck     <= 1'b0;
         tms     <= 1'b1;
         tdi     <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end
      else
      begin
         case (state_q)
            JSR_IDLE:
            begin
               done <= 1'b0;
               if (start)
               begin
                  state_q <= JSR_RUN;
                  busy    <= 1'b1;
                  ph_q    <= '0;
                  step_q  <= '0;
                  cnt_q   <= '0;
                  // the opening reset walk starts with tms high
                  tms     <= 1'b1;
                  tdi     <= 1'b0;
               end
            end
            default:
            begin
               if (ph_q == PH_RISE)
               begin
                  tck  <= 1'b1;
                  ph_q <= ph_q + 8'h01;
               end
               else if (adv)
               begin
                  tck  <= 1'b0;
                  ph_q <= '0;
                  if (!lastBit)
                  begin
                     cnt_q <= cnt_q + 32'h1;
                     tdi   <= tdiBit(cur.kind, cnt_q + 32'h1);
                  end
                  else if (step_q == `JSR_S_FINAL)
                  begin
                     state_q <= JSR_IDLE;
                     busy    <= 1'b0;
                     done    <= 1'b1;
                     tdi     <= 1'b0;
                  end
                  else
                  begin
                     step_q <= step_q + 5'h01;
                     cnt_q  <= '0;
                     tms    <= nxt.tms;
                     tdi    <= tdiBit(nxt.kind, 32'h0);
                  end
               end
               else if (ph_q != PH_LAST)
                  ph_q <= ph_q + 8'h01;
            end
         endcase
      end
   end

   // R11 R12 tdo sampled at the end of each shift cycle, msb of word first
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rbShift_q   <= '0;
         rbCnt_q     <= '0;
         wordValid_q <= 1'b0;
         wordData_q  <= '0;
      end
      else
      begin
         if (adv && cur.sample)
         begin
            rbShift_q <= {rbShift_q[30:0], tdoSync};
            rbCnt_q   <= rbCnt_q + 5'h01;
         end
         if (adv && cur.sample && rbCnt_q == 5'h1F)
         begin
            wordValid_q <= 1'b1;
            wordData_q  <= {rbShift_q[30:0], tdoSync};
         end
         else if (wordValid_q && fillBus.ready)
            wordValid_q <= 1'b0;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_shut_bits: assert property (adv && step_q == `JSR_S_SHUT |->
      !tms && tdi == IR_SHUT[cnt_q[3:0]]) else $error("shutdown bit wrong"); // R1
   a_rti_dwell: assert property (step_q == `JSR_S_RTI + 5'h01 && $past(step_q) == `JSR_S_RTI
      |-> $past(cnt_q) == `JSR_N_RTI - 32'h1 && $past(tms) == 1'b0)
      else $error("idle dwell not twelve"); // R2
   a_cin_bits: assert property (adv && step_q == `JSR_S_CFGIN |->
      !tms && tdi == IR_CIN[cnt_q[3:0]]) else $error("cfg-write bit wrong"); // R3
   a_cin_msb: assert property (adv && step_q == `JSR_S_CFGIN_MSB |-> tms && tdi)
      else $error("cfg-write msb wrong"); // R4
   a_pkt_length: assert property (step_q == `JSR_S_PKT_LAST && $past(step_q) == `JSR_S_PKT
      |-> $past(cnt_q) == `JSR_N_PKT - 32'h1) else $error("packet length wrong"); // R5
   a_pkt_last: assert property (adv && step_q == `JSR_S_PKT_LAST |-> tms && !tdi)
      else $error("last packet bit wrong"); // R6
   a_to_selir: assert property (adv && step_q == `JSR_S_TOIR |-> tms && cnt_q < 32'h3)
      else $error("exit to select-ir wrong"); // R7
   a_enter_ir: assert property (adv && step_q == `JSR_S_IRENTER |-> !tms ##1 step_q <= `JSR_S_CFGOUT)
      else $error("shift-ir entry wrong"); // R8
   a_cout_bits: assert property (adv && step_q == `JSR_S_CFGOUT |->
      !tms && tdi == IR_COUT[cnt_q[3:0]]) else $error("cfg-read bit wrong"); // R9
   a_cout_msb: assert property (adv && step_q == `JSR_S_CFGOUT_MSB |-> tms && tdi)
      else $error("cfg-read msb wrong"); // R10
   a_rb_length: assert property (step_q == `JSR_S_RB_LAST && $past(step_q) == `JSR_S_RB
      |-> $past(cnt_q) == RB_BITS - 32'h2 && rbCnt_q == 5'h1F) else $error("readback length"); // R11
   a_rb_last: assert property (adv && step_q == `JSR_S_RB_LAST |-> tms ##1 wordValid_q)
      else $error("last readback word lost"); // R12
   a_finish: assert property ($rose(done) |-> tms && $past(step_q) == `JSR_S_FINAL && !busy)
      else $error("finish sequence wrong"); // R13
endmodule
`default_nettype wire

//--- rtl/jsr_pin_sync.sv
/*
   Three-stage pin synchroniser; the output follows once stages two and
   three agree. Assumes an asynchronous input and a synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module jsr_pin_sync
(
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic pinIn,
   output var  logic pinOut
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // filters a one-cycle glitch at the cost of one more cycle of latency
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         pinOut <= 1'b0;
      else if (s2_q == s3_q)
         pinOut <= s3_q;
   end
endmodule
`default_nettype wire

//--- rtl/jsr_word_fifo.sv
/*
   Small word buffer with registered outputs on both sides.
   Assumes one clock; the drain side may stall freely.
*/
`timescale 1ns/1ns
`default_nettype none
module jsr_word_fifo
#(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 2
)
(
   input  wire logic             clock,
   input  wire logic             sys_rst,
   jsr_stream_if.snk             fill,
   output var  logic [WIDTH-1:0] outData,
   output var  logic             outValid,
   input  wire logic             outReady
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH != 2 ** AW || DEPTH < 2)
      $error("jsr_word_fifo: DEPTH must be a power of two, at least 2");

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;
   logic [AW-1:0]    rdPtr_d;
   logic [AW:0]      count_d;

   always_comb
   begin
      push    = fill.valid && fill.ready;
      pop     = outValid && outReady;
      rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
      count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clock)
   begin
      if (push)
         mem_q[wrPtr_q] <= fill.data;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wrPtr_q    <= '0;
         rdPtr_q    <= '0;
         count_q    <= '0;
         outValid   <= 1'b0;
         fill.ready <= 1'b0;
         outData    <= '0;
      end
      else
      begin
         wrPtr_q    <= push ? wrPtr_q + 1'b1 : wrPtr_q;
         rdPtr_q    <= rdPtr_d;
         count_q    <= count_d;
         outValid   <= count_d != '0;
         fill.ready <= count_d != (AW + 1)'(DEPTH);
         // head word bypasses the array when it is written this very cycle
         outData    <= (push && wrPtr_q == rdPtr_d) ? fill.data : mem_q[rdPtr_d];
      end
   end
endmodule
`default_nettype wire

//--- tb/jsr_tap_model.sv
/*
   Behavioural device at the far end of the test port: tap controller,
   instruction register, configuration-write decode and frame readout.
   Assumes tck stands still between transfers.
*/
`timescale 1ns/1ns
`default_nettype none
module jsr_tap_model
#(
   parameter int unsigned PAD_WORDS  = 1,
   parameter logic [31:0] PAD_WORD   = 32'h0F0F0F0F,
   parameter logic [31:0] FRAME_BASE = 32'h96E13C00
)
(
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   output var  logic tdo
);
   typedef enum logic [3:0] {TLR, RTI, SDR, CDR, SHDR, E1DR, PDR, E2DR, UDR,
                             SIR, CIR, SHIR, E1IR, PIR, E2IR, UIR} jsr_tap_e;
   jsr_tap_e    st = TLR;
   logic [9:0]  ir = 10'h3FF;
   logic [9:0]  irSh = 10'h000;
   logic [31:0] drSh = 32'h00000000;
   logic [31:0] rbw;
   logic        synced = 1'b0;
   logic        rdArmed = 1'b0;
   logic        exitBit = 1'b1;
   int          irBits = 0;
   int          drBits = 0;
   int          badIr = 0;
   int          rtiCount = 0;
   int          rbBit = 0;
   int          tmsRun = 0;
   logic [9:0]  irLog [$];
   logic [31:0] pktLog [$];
   initial tdo = 1'b0;

   function automatic jsr_tap_e nxt(input jsr_tap_e s, input logic m);
      case (s)
         TLR:           return m ? TLR : RTI;
         RTI, UDR, UIR: return m ? SDR : RTI;
         SDR:           return m ? SIR : CDR;
         CDR, SHDR:     return m ? E1DR : SHDR;
         E1DR:          return m ? UDR : PDR;
         PDR:           return m ? E2DR : PDR;
         E2DR:          return m ? UDR : SHDR;
         SIR:           return m ? TLR : CIR;
         CIR, SHIR:     return m ? E1IR : SHIR;
         E1IR:          return m ? UIR : PIR;
         PIR:           return m ? E2IR : PIR;
         default:       return m ? UIR : SHIR;
      endcase
   endfunction

   task automatic clear_logs();
      irLog.delete();
      pktLog.delete();
      badIr = 0;
      rtiCount = 0;
      rbBit = 0;
      exitBit = 1'b1;
   endtask

   always @(posedge tck)
   begin
      tmsRun = tms ? tmsRun + 1 : 0;
      if (st == TLR)
      begin
         synced = 1'b0;
         rdArmed = 1'b0;
         ir = 10'h3FF;
      end
      if (st == CIR)
         irBits = 0;
      if (st == SHIR)
      begin
         irSh = {tdi, irSh[9:1]};
         irBits++;
      end
      if (st == E1IR && tms)
      begin
         ir = irSh;
         irLog.push_back(irSh);
         // the closing walk passes update-ir after a single shifted bit
         badIr += (irBits != 10 && irLog.size() < 4);
      end
      if (ir == 10'h3CD && !tms && (st == UIR || st == RTI))
         rtiCount++;
      if (st == SHDR && ir == 10'h3C5)
      begin
         drSh = {drSh[30:0], tdi};
         drBits++;
         if (synced && drBits == 32)
            pktLog.push_back(drSh);
         if (synced && drBits == 32 && drSh == 32'h28006000)
            rdArmed = 1'b1;
         if (drBits == 32 || drSh == 32'hAA995566)
            drBits = 0;
         if (drSh == 32'hAA995566)
            synced = 1'b1;
         if (tms)
            exitBit = tdi;
      end
      if (st == CDR)
         rbBit = 0;
      // one bit per shift cycle, exit cycle included
      if (st == SHDR && ir == 10'h3C4 && rdArmed)
         rbBit++;
      st = nxt(st, tms);
   end

   // pad frame first, then raw frame words; no crc folded in
   // released line toggles so a stale value never passes for data
   always @(negedge tck)
   begin
      rbw = (rbBit / 32 < PAD_WORDS) ? PAD_WORD : FRAME_BASE + rbBit / 32;
      if (st == SHDR && ir == 10'h3C4 && rdArmed)
         tdo <= rbw[31 - rbBit % 32];
      else
         tdo <= ~tdo;
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
   Self-checking bench of the shutdown/readback host against a device model.
   Assumes the host runs its fixed sequence once per start.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int unsigned RBW   = 6;
   localparam logic [31:0] PAD   = 32'h0F0F0F0F;
   localparam logic [31:0] FBASE = 32'h96E13C00;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        start = 1'b0;
   logic        rbReady = 1'b0;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo;
   logic        busy;
   logic        done;
   logic [31:0] rbData;
   logic        rbValid;
   logic [31:0] rxq [$];
   int          errors = 0;
   int          compares = 0;
   logic [31:0] expPkt [9] = '{32'h20000000, 32'h30008001, 32'h00000004,
      32'h30002001, 32'h00000000, 32'h28006000, 32'h48024090, 32'h20000000,
      32'h20000000};

   jsr_host #(.TCK_HALF(4), .RB_WORDS(RBW), .BUF_DEPTH(2)) i_dut
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .start   (start),
      .tdoPin  (tdo),
      .tck     (tck),
      .tms     (tms),
      .tdi     (tdi),
      .busy    (busy),
      .done    (done),
      .rbData  (rbData),
      .rbValid (rbValid),
      .rbReady (rbReady)
   );
   jsr_tap_model #(.PAD_WORDS(1), .PAD_WORD(PAD), .FRAME_BASE(FBASE)) i_dev
   (
      .tck (tck),
      .tms (tms),
      .tdi (tdi),
      .tdo (tdo)
   );

   always #25 clock = ~clock;

   always @(posedge clock)
      if (rbValid === 1'b1 && rbReady === 1'b1)
         rxq.push_back(rbData);

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic launch(input logic ready);
      i_dev.clear_logs();
      rxq.delete();
      rbReady = ready;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      check("busy after start", 1, busy);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 40000)
      begin
         @(negedge clock);
         n++;
      end
      check("done pulse", 1, done);
      @(negedge clock);
      check("done after pulse", 0, done);
      check("busy after done", 0, busy);
   endtask

   task automatic verify_run();
      check("ir loads", 4, i_dev.irLog.size());
      check("shutdown ir", 32'h000003CD, 32'(i_dev.irLog[0]));
      check("config write ir", 32'h000003C5, 32'(i_dev.irLog[1]));
      check("config read ir", 32'h000003C4, 32'(i_dev.irLog[2]));
      check("ir shift lengths", 0, i_dev.badIr);
      check("idle dwell", 12, i_dev.rtiCount);
      check("packet count", 9, i_dev.pktLog.size());
      for (int k = 0; k < 9; k++)
         check("packet word", expPkt[k], i_dev.pktLog[k]);
      check("exit bit", 0, i_dev.exitBit);
      check("readback bits", RBW * 32, i_dev.rbBit);
      check("words received", RBW, rxq.size());
      for (int k = 0; k < RBW; k++)
         check("readback word", (k == 0) ? PAD : FBASE + k, rxq[k]);
      check("closing tms run", 3, i_dev.tmsRun);
   endtask

   task automatic test_reset();
      check("tck at reset", 0, tck);
      check("tms at reset", 1, tms);
      check("tdi at reset", 0, tdi);
      check("busy at reset", 0, busy);
      check("valid at reset", 0, rbValid);
      $display("test reset values finished");
   endtask

   task automatic test_prompt();
      launch(1'b1);
      wait_done();
      verify_run();
      $display("test prompt drain finished");
   endtask

   // stall long enough that an unstretched link would overrun the buffer
   task automatic test_stall();
      logic [31:0] w;
      int          n;
      launch(1'b0);
      n = 0;
      while (rbValid !== 1'b1 && n < 20000)
      begin
         @(negedge clock);
         n++;
      end
      w = rbData;
      repeat (2000) @(negedge clock);
      start = 1'b1;
      check("stalled valid", 1, rbValid);
      check("stalled word", PAD, rbData);
      check("held word", w, rbData);
      check("link stretched", 1, 32'(i_dev.rbBit < RBW * 32));
      @(negedge clock);
      start = 1'b0;
      rbReady = 1'b1;
      wait_done();
      verify_run();
      $display("test stalled drain finished");
   endtask

   initial
   begin
      repeat (12) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      test_reset();
      test_prompt();
      test_stall();
      end_of_test();
   end

   initial
   begin
      repeat (30000) @(posedge clock);
      errors++;
      $display("Error watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule
`default_nettype wire
